// file: rtl/mfe_front_end.sv
// registered module front end: command register, parity, data lane, strobes, sideband
// ==========================================
// What this block does
// - redundant strobe drives only with read data, ignored during writes
// - redundant strobe disabled: its pin is the write byte mask
// - complement redundant strobe only with redundant and differential modes on
// - parity errors on command/address shown on open-drain active-low output
// - one wide core transfer per access, eight half-cycle beats at pins
// - read strobe edges align with data; write strobe centred by controller
// - command inputs sampled at each rising edge of the host clock
// - write data caught on both strobe edges; reads launched on both
// - presence store holds 256 bytes, factory lower half, user upper half
// - system is two-wire master; address select pins choose slave address
// - presence store write protection permanently off
// - commands captured on one rising edge, forwarded on the next
// - host clock redriven to all memory devices
// - programmable event and critical thresholds drive active-low event output
// - parity covers address, row, column and write-enable strobes
// - module reset pin forces captured and forwarded command registers low
// - beat sampled with byte mask high is not written
module mfe_front_end
   import mfe_pkg::*;
#(
   parameter int DQ_W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdData,
   // host command pins
   input wire logic hostCk,
   input wire mfe_cmd_t hostCmd,
   input wire logic parIn,
   input wire logic moduleRst_n,
   // forwarded to memory devices
   output logic dramCk,
   output mfe_cmd_t dramCmd,
   // parity error, open drain
   output logic errOutO,
   output logic errOutOe,
   // data lane
   input wire logic [DQ_W-1:0] dqIn,
   output logic [DQ_W-1:0] dqO,
   output logic dqOe,
   input wire logic dqsIn,
   output logic dqsO,
   output logic dqsOe,
   output logic dqsNO,
   output logic dqsNOe,
   input wire logic redStrobeIn,
   output logic redStrobeO,
   output logic redStrobeOe,
   output logic redStrobeNO,
   output logic redStrobeNOe,
   // core side
   input wire logic [DQ_W*BURST_BEATS-1:0] coreRdData,
   output logic coreRdReq,
   output logic [DQ_W*BURST_BEATS-1:0] coreWrData,
   output logic [BURST_BEATS-1:0] coreWrMask,
   output logic coreWrValid,
   // temperature
   input wire logic [7:0] tempNow,
   output logic eventO,
   output logic eventOe,
   // presence-detect sideband
   input wire logic spdScl,
   input wire logic spdSdaIn,
   output logic spdSdaO,
   output logic spdSdaOe,
   input wire logic [2:0] serialAddrSelect
);
   localparam int LANE_W = DQ_W * BURST_BEATS;

   initial begin
      if (DQ_W < 1 || DQ_W > 32) $error("DQ_W out of range");
   end

   // ==========================================
   // pin synchronisers
   mfe_cmd_t cmdS1_r, cmdS2_r;
   logic [4:0] pinS1_r, pinS2_r;
   logic [DQ_W-1:0] dqS1_r, dqS2_r;
   logic ckS, parS, modRstS_n, dqsS, maskS;

   always_ff @(posedge clk) begin
      cmdS1_r <= hostCmd;
      cmdS2_r <= cmdS1_r;
      pinS1_r <= {redStrobeIn, dqsIn, moduleRst_n, parIn, hostCk};
      pinS2_r <= pinS1_r;
      dqS1_r <= dqIn;
      dqS2_r <= dqS1_r;
   end

   assign ckS = pinS2_r[0];
   assign parS = pinS2_r[1];
   assign modRstS_n = pinS2_r[2];
   assign dqsS = pinS2_r[3];
   assign maskS = pinS2_r[4];

   logic ckPrev_r, dqsPrev_r, ckRise, ckEdge, dqsEdge;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ckPrev_r <= 1'b0;
         dqsPrev_r <= 1'b0;
      end else begin
         ckPrev_r <= ckS;
         dqsPrev_r <= dqsS;
      end
   end

   assign ckRise = ckS & ~ckPrev_r;
   assign ckEdge = ckS ^ ckPrev_r;
   assign dqsEdge = dqsS ^ dqsPrev_r;

   // ==========================================
   // registers
   logic redEn_r, diffEn_r, perr_r, critFlag_r;
   logic [2:0] casLat_r;
   logic [7:0] evtTh_r, critTh_r;
   logic [31:0] rdMux;
   logic parityBad;
   mfe_state_t state_r;

   // even parity across the covered fields plus the parity pin
   assign parityBad = ^{cmdS2_r.addr, cmdS2_r.rasN, cmdS2_r.casN, cmdS2_r.weN, parS};

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         redEn_r <= 1'b0;
         diffEn_r <= 1'b0;
         casLat_r <= CL_RESET;
         evtTh_r <= EVT_TH_RESET;
         critTh_r <= CRIT_TH_RESET;
      end else if (regWr && regAddr == REG_CTRL) begin
         redEn_r <= regWrData[CTRL_RED_BIT];
         diffEn_r <= regWrData[CTRL_DIFF_BIT];
         casLat_r <= regWrData[CTRL_CL_LSB +: 3];
      end else if (regWr && regAddr == REG_TEMP) begin
         evtTh_r <= regWrData[TEMP_EVT_LSB +: 8];
         critTh_r <= regWrData[TEMP_CRIT_LSB +: 8];
      end
   end

   // sticky parity flag, write one to clear, a new error wins
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         perr_r <= 1'b0;
      end else if (ckRise && parityBad) begin
         perr_r <= 1'b1;
      end else if (regWr && regAddr == REG_STAT && regWrData[STAT_PERR_BIT]) begin
         perr_r <= 1'b0;
      end
   end

   always_comb begin
      rdMux = 32'h0000_0000;
      case (regAddr)
         REG_CTRL: begin
            rdMux[CTRL_RED_BIT] = redEn_r;
            rdMux[CTRL_DIFF_BIT] = diffEn_r;
            rdMux[CTRL_CL_LSB +: 3] = casLat_r;
         end
         REG_STAT: begin
            rdMux[STAT_PERR_BIT] = perr_r;
            rdMux[STAT_EVT_BIT] = eventOe;
            rdMux[STAT_CRIT_BIT] = critFlag_r;
            rdMux[STAT_STATE_LSB +: 2] = state_r;
         end
         REG_TEMP: rdMux[15:0] = {critTh_r, evtTh_r};
         REG_TNOW: rdMux[7:0] = tempNow;
         default: rdMux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         regRdData <= 32'h0000_0000;
      end else begin
         regRdData <= regRd ? rdMux : 32'h0000_0000;
      end
   end

   // ==========================================
   // command register stage and clock redrive
   mfe_cmd_t capt_r;

   always_ff @(posedge clk) begin
      if (!rst_n || !modRstS_n) begin
         capt_r <= '0;
         dramCmd <= '0;
      end else if (ckRise) begin
         capt_r <= cmdS2_r;
         dramCmd <= capt_r;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dramCk <= 1'b0;
      end else begin
         dramCk <= ckS;
      end
   end

   // error held from one host rising edge to the next
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         errOutO <= 1'b0;
         errOutOe <= 1'b0;
      end else if (ckRise) begin
         errOutOe <= parityBad & modRstS_n;
      end
   end

   // ==========================================
   // access sequencer
   logic fwdRead, fwdWrite, burstStart, burstEnd, wrBeat, wrLast;
   logic [2:0] lat_r, beat_r;

   assign fwdRead = ckRise & modRstS_n & ~capt_r.csN
      & ({capt_r.rasN, capt_r.casN, capt_r.weN} == CMD_READ);
   assign fwdWrite = ckRise & modRstS_n & ~capt_r.csN
      & ({capt_r.rasN, capt_r.casN, capt_r.weN} == CMD_WRITE);
   // latency counts from the forwarding edge, adding the register cycle
   assign burstStart = (state_r == ST_RLAT) & ckRise & (lat_r == 3'h0);
   assign burstEnd = (state_r == ST_RBURST) & ckEdge & (beat_r == LAST_BEAT);
   assign wrBeat = (state_r == ST_WCAP) & dqsEdge;
   assign wrLast = wrBeat & (beat_r == LAST_BEAT);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         lat_r <= 3'h0;
         beat_r <= 3'h0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               beat_r <= 3'h0;
               if (fwdRead) begin
                  state_r <= ST_RLAT;
                  lat_r <= casLat_r - 3'h1;
               end else if (fwdWrite) begin
                  state_r <= ST_WCAP;
               end
            end
            ST_RLAT: begin
               if (burstStart) begin
                  state_r <= ST_RBURST;
               end else if (ckRise) begin
                  lat_r <= lat_r - 3'h1;
               end
            end
            ST_RBURST: begin
               if (burstEnd) begin
                  state_r <= ST_IDLE;
               end else if (ckEdge) begin
                  beat_r <= beat_r + 3'h1;
               end
            end
            ST_WCAP: begin
               if (wrLast) begin
                  state_r <= ST_IDLE;
               end else if (wrBeat) begin
                  beat_r <= beat_r + 3'h1;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ==========================================
   // read launch: data and strobes change together
   logic [LANE_W-1:0] rdBuf_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdBuf_r <= '0;
         coreRdReq <= 1'b0;
         dqO <= '0;
         dqOe <= 1'b0;
         dqsO <= 1'b0;
         dqsOe <= 1'b0;
         dqsNO <= 1'b0;
         dqsNOe <= 1'b0;
         redStrobeO <= 1'b0;
         redStrobeOe <= 1'b0;
         redStrobeNO <= 1'b0;
         redStrobeNOe <= 1'b0;
      end else begin
         coreRdReq <= burstStart;
         if (burstStart) begin
            rdBuf_r <= coreRdData >> DQ_W;
            dqO <= coreRdData[DQ_W-1:0];
            dqOe <= 1'b1;
            dqsO <= 1'b1;
            dqsOe <= 1'b1;
            dqsNO <= 1'b0;
            dqsNOe <= diffEn_r;
            redStrobeO <= 1'b1;
            redStrobeOe <= redEn_r;
            redStrobeNO <= 1'b0;
            redStrobeNOe <= redEn_r & diffEn_r;
         end else if (burstEnd) begin
            dqOe <= 1'b0;
            dqsOe <= 1'b0;
            dqsNOe <= 1'b0;
            redStrobeOe <= 1'b0;
            redStrobeNOe <= 1'b0;
         end else if (state_r == ST_RBURST && ckEdge) begin
            dqO <= rdBuf_r[DQ_W-1:0];
            rdBuf_r <= rdBuf_r >> DQ_W;
            dqsO <= ~dqsO;
            dqsNO <= dqsO;
            redStrobeO <= ~redStrobeO;
            redStrobeNO <= redStrobeO;
         end
      end
   end

   // ==========================================
   // write capture on both strobe edges
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         coreWrData <= '0;
         coreWrMask <= '0;
         coreWrValid <= 1'b0;
      end else begin
         coreWrValid <= wrLast;
         if (wrBeat) begin
            coreWrData <= {dqS2_r, coreWrData[LANE_W-1:DQ_W]};
            // masked beat is flagged so the core skips it
            coreWrMask <= {maskS & ~redEn_r, coreWrMask[BURST_BEATS-1:1]};
         end
      end
   end

   // ==========================================
   // temperature event
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         eventO <= 1'b0;
         eventOe <= 1'b0;
         critFlag_r <= 1'b0;
      end else begin
         eventOe <= (tempNow >= evtTh_r) | (tempNow >= critTh_r);
         critFlag_r <= tempNow >= critTh_r;
      end
   end

   // ==========================================
   // presence-detect store
   mfe_spd_store u_spd (
      .clk(clk),
      .rst_n(rst_n),
      .scl(spdScl),
      .sdaIn(spdSdaIn),
      .sdaO(spdSdaO),
      .sdaOe(spdSdaOe),
      .addrSel(serialAddrSelect)
   );

   // ==========================================
   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence rdLaunch;
      $rose(dqOe);
   endsequence

   sequence wrCapture;
      wrBeat && redEn_r;
   endsequence

   parity_err_a: assert property (ckRise && parityBad && modRstS_n |=> errOutOe)
      else $error("parity error not flagged");
   err_hold_a: assert property ($fell(errOutOe) |-> $past(ckRise))
      else $error("parity error dropped between host edges");
   fwd_stage_a: assert property (ckRise && modRstS_n |=> dramCmd == $past(capt_r))
      else $error("command not forwarded from capture stage");
   mod_rst_a: assert property (!modRstS_n |=> dramCmd == '0)
      else $error("module reset did not clear outputs");
   red_write_a: assert property (state_r == ST_WCAP |-> !redStrobeOe)
      else $error("redundant strobe driven during write");
   red_comp_a: assert property (redStrobeNOe |-> redEn_r && diffEn_r)
      else $error("complement strobe driven when not allowed");
   mask_off_a: assert property (wrCapture |=> !coreWrMask[BURST_BEATS-1])
      else $error("mask taken while redundant strobe on");
   rd_launch_a: assert property (rdLaunch |-> coreRdReq && dqsOe)
      else $error("read launch without core transfer");
   dqs_align_a: assert property (dqOe && $changed(dqO) |-> $changed(dqsO))
      else $error("read data moved without strobe edge");
   event_a: assert property (tempNow >= evtTh_r |=> eventOe)
      else $error("temperature event not raised");
endmodule

// file: rtl/mfe_pkg.sv
// shared constants and types for the registered module front end
package mfe_pkg;
   // ==========================================
   // register port map
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STAT = 4'h4;
   localparam logic [3:0] REG_TEMP = 4'h8;
   localparam logic [3:0] REG_TNOW = 4'hC;
   localparam int CTRL_RED_BIT = 0;
   localparam int CTRL_DIFF_BIT = 1;
   localparam int CTRL_CL_LSB = 4;
   localparam logic [2:0] CL_RESET = 3'h3;
   localparam int STAT_PERR_BIT = 0;
   localparam int STAT_EVT_BIT = 1;
   localparam int STAT_CRIT_BIT = 2;
   localparam int STAT_STATE_LSB = 4;
   localparam int TEMP_EVT_LSB = 0;
   localparam int TEMP_CRIT_LSB = 8;
   localparam logic [7:0] EVT_TH_RESET = 8'h55;
   localparam logic [7:0] CRIT_TH_RESET = 8'h5F;
   // ==========================================
   // burst and command coding
   localparam int BURST_BEATS = 8;
   localparam logic [2:0] LAST_BEAT = 3'h7;
   localparam logic [2:0] CMD_READ = 3'h5;
   localparam logic [2:0] CMD_WRITE = 3'h4;
   // ==========================================
   // presence-detect store
   localparam int SPD_BYTES = 256;
   localparam int SPD_FACTORY = 128;
   localparam logic [3:0] SPD_DEV_TYPE = 4'hA;
   localparam logic [3:0] BIT_DONE = 4'h8;

   typedef struct packed {
      logic csN;
      logic rasN;
      logic casN;
      logic weN;
      logic cke;
      logic odt;
      logic [2:0] ba;
      logic [14:0] addr;
   } mfe_cmd_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_RLAT = 2'h1,
      ST_RBURST = 2'h3,
      ST_WCAP = 2'h2
   } mfe_state_t;

   typedef enum logic [2:0] {
      SP_IDLE = 3'h0,
      SP_DEV = 3'h1,
      SP_ADDR = 3'h3,
      SP_WR = 3'h2,
      SP_RD = 3'h6
   } mfe_spd_phase_t;
endpackage

// file: rtl/mfe_spd_store.sv
// presence-detect byte store behind a two-wire slave port
module mfe_spd_store
   import mfe_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // two-wire pins
   input wire logic scl,
   input wire logic sdaIn,
   output logic sdaO,
   output logic sdaOe,
   input wire logic [2:0] addrSel
);
   logic [1:0] sclS_r, sdaS_r;
   logic sclP_r, sdaP_r;
   logic sclRise, sclFall, startC, stopC, memWr, nack_r;
   mfe_spd_phase_t phase_r;
   logic [3:0] bitCnt_r;
   logic ackPh_r;
   logic [7:0] shift_r, ptr_r, tx_r;
   // lower half holds factory contents, upper half is free for users
   logic [7:0] mem [SPD_BYTES];

   initial begin
      if (SPD_FACTORY * 2 != SPD_BYTES) $error("store halves mismatch");
   end

   // ==========================================
   // pin sampling and bus conditions
   always_ff @(posedge clk) begin
      sclS_r <= {sclS_r[0], scl};
      sdaS_r <= {sdaS_r[0], sdaIn};
      sclP_r <= sclS_r[1];
      sdaP_r <= sdaS_r[1];
   end

   assign sclRise = sclS_r[1] & ~sclP_r;
   assign sclFall = ~sclS_r[1] & sclP_r;
   assign startC = sclS_r[1] & sclP_r & sdaP_r & ~sdaS_r[1];
   assign stopC = sclS_r[1] & sclP_r & ~sdaP_r & sdaS_r[1];
   // no protect input: writes are never blocked
   assign memWr = sclFall & ~startC & ~stopC & ~ackPh_r & (bitCnt_r == BIT_DONE)
      & (phase_r == SP_WR);
   // open-drain data: only the enable ever moves
   always_ff @(posedge clk) begin
      sdaO <= 1'b0;
   end

   // ==========================================
   // slave sequencer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         phase_r <= SP_IDLE;
         bitCnt_r <= 4'h0;
         ackPh_r <= 1'b0;
         sdaOe <= 1'b0;
         shift_r <= 8'h00;
         ptr_r <= 8'h00;
         tx_r <= 8'h00;
         nack_r <= 1'b0;
      end else if (startC) begin
         phase_r <= SP_DEV;
         bitCnt_r <= 4'h0;
         ackPh_r <= 1'b0;
         sdaOe <= 1'b0;
      end else if (stopC) begin
         phase_r <= SP_IDLE;
         sdaOe <= 1'b0;
      end else if (sclRise && phase_r != SP_IDLE) begin
         if (ackPh_r) begin
            nack_r <= sdaS_r[1];
         end else begin
            shift_r <= {shift_r[6:0], sdaS_r[1]};
            bitCnt_r <= bitCnt_r + 4'h1;
         end
      end else if (sclFall && phase_r != SP_IDLE) begin
         if (ackPh_r) begin
            ackPh_r <= 1'b0;
            bitCnt_r <= 4'h0;
            sdaOe <= (phase_r == SP_RD) & ~nack_r & ~tx_r[7];
            if (phase_r == SP_RD && nack_r) begin
               phase_r <= SP_IDLE;
            end
         end else if (bitCnt_r == BIT_DONE) begin
            ackPh_r <= 1'b1;
            case (phase_r)
               SP_DEV: begin
                  // address pins pick the slave address
                  if (shift_r[7:1] == {SPD_DEV_TYPE, addrSel}) begin
                     sdaOe <= 1'b1;
                     nack_r <= 1'b0;
                     tx_r <= mem[ptr_r];
                     phase_r <= shift_r[0] ? SP_RD : SP_ADDR;
                  end else begin
                     phase_r <= SP_IDLE;
                     ackPh_r <= 1'b0;
                  end
               end
               SP_ADDR: begin
                  ptr_r <= shift_r;
                  sdaOe <= 1'b1;
                  phase_r <= SP_WR;
               end
               SP_WR: begin
                  ptr_r <= ptr_r + 8'h01;
                  sdaOe <= 1'b1;
               end
               SP_RD: begin
                  sdaOe <= 1'b0;
                  ptr_r <= ptr_r + 8'h01;
                  tx_r <= mem[ptr_r + 8'h01];
               end
               default: phase_r <= SP_IDLE;
            endcase
         end else if (phase_r == SP_RD) begin
            sdaOe <= ~tx_r[3'h7 - bitCnt_r[2:0]];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (memWr) begin
         mem[ptr_r] <= shift_r;
      end
   end
endmodule

// file: tb/mfe_host_model.sv
// host controller model: link clock, command pins and write data lane
module mfe_host_model
   import mfe_pkg::*;
(
   // link clock and command pins
   output logic hostCk,
   output mfe_cmd_t hostCmd,
   output logic parIn,
   // write data lane
   output logic [7:0] dqOut,
   output logic dqsOut,
   output logic maskOut
);
   timeunit 1ns;
   timeprecision 1ps;
   // ===========
   // free-running single-ended host clock, deselect at idle
   initial begin
      hostCk = 1'b0;
      hostCmd = '1;
      parIn = 1'b0;
      dqOut = 8'hA5;
      dqsOut = 1'b0;
      maskOut = 1'b0;
      forever #80 hostCk = ~hostCk;
   end
   // command held a full period around the capturing rise
   task send(input mfe_cmd_t c, input logic bad);
      @(negedge hostCk);
      hostCmd <= c;
      parIn <= ^{c.addr, c.rasN, c.casN, c.weN} ^ bad;
      @(negedge hostCk);
      hostCmd <= '1;
      parIn <= 1'b0;
   endtask
   // strobe edge in the middle of each data eye
   task wrBurst(input logic [63:0] d, input logic [7:0] m);
      for (int i = 0; i < 8; i++) begin
         dqOut <= d[8*i +: 8];
         maskOut <= m[i];
         #20 dqsOut <= ~dqsOut;
         #20;
      end
      dqOut <= ~dqOut;
      maskOut <= ~maskOut;
   endtask
endmodule

// file: tb/registered_ddr2_module_front_end_test.sv
// self-checking bench for the registered module front end
module registered_ddr2_module_front_end_test;
   import mfe_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, regWr, regRd, moduleRst_n, spdScl, spdSdaIn, parIn, hostCk;
   logic hostDqs, hostMask, dramCk, errOutO, errOutOe, dqOe, dqsIn, dqsO, dqsOe;
   logic dqsNO, dqsNOe, coreRdReq, coreWrValid, redStrobeIn, redStrobeO, redStrobeOe;
   logic redStrobeNO, redStrobeNOe, eventO, eventOe, spdSdaO, spdSdaOe, mSda;
   logic [8:0] r9;
   logic [3:0] regAddr;
   logic [31:0] regWrData, regRdData, lfsrState, d;
   logic [63:0] coreRdData, coreWrData, wd, gotD;
   mfe_cmd_t hostCmd, dramCmd, c;
   logic [7:0] dqIn, dqO, hostDq, coreWrMask, tempNow, mk, gotM;
   logic [2:0] serialAddrSelect, cl;
   logic [5:0] lane;
   int errors, samples_checked, k, clv;
   // ===========
   // shared wires and instances
   assign dqIn = dqOe ? dqO : hostDq;
   assign dqsIn = dqsOe ? dqsO : hostDqs;
   assign redStrobeIn = redStrobeOe ? redStrobeO : hostMask;
   assign spdSdaIn = mSda & ~spdSdaOe;
   assign lane = {dqOe, dqsOe, dqsNOe, redStrobeOe, redStrobeNOe, dqsO};
   mfe_front_end #(.DQ_W(8)) DUT (.*);
   mfe_host_model host (.hostCk(hostCk), .hostCmd(hostCmd), .parIn(parIn),
      .dqOut(hostDq), .dqsOut(hostDqs), .maskOut(hostMask));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ===========
   // helpers
   function logic [31:0] rnd();
      lfsrState = {lfsrState[30:0], ^(lfsrState & 32'h80200003)};
      return lfsrState;
   endfunction
   function mfe_cmd_t opCmd(input logic we);
      mfe_cmd_t o;
      logic [31:0] r;
      r = rnd();
      o = mfe_cmd_t'(r[23:0]);
      {o.csN, o.rasN, o.casN, o.weN} = {3'h2, ~we};
      return o;
   endfunction
   function logic expEvent(input logic [7:0] t, input logic [7:0] ev, input logic [7:0] cr);
      return (t >= ev) || (t >= cr);
   endfunction
   function logic [5:0] expLane(input logic [1:0] m, input logic odd);
      return {2'h3, m[1], m[0], &m, ~odd};
   endfunction
   task checkVal(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task regWrite(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      regAddr <= a;
      regWrData <= v;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task regRead(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      v = regRdData;
   endtask
   // two-wire start (1,0) or stop (0,1) around one clock pulse
   task i2cCond(input logic s0, input logic s1);
      spdScl <= 1'b0;
      repeat (12) @(posedge clk);
      mSda <= s0;
      repeat (12) @(posedge clk);
      spdScl <= 1'b1;
      repeat (12) @(posedge clk);
      mSda <= s1;
      repeat (12) @(posedge clk);
   endtask
   // nine bits: byte plus acknowledge slot, line sampled mid high phase
   task i2cXfer(input logic [8:0] v, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) begin
         spdScl <= 1'b0;
         repeat (12) @(posedge clk);
         mSda <= v[i];
         repeat (12) @(posedge clk);
         spdScl <= 1'b1;
         repeat (12) @(posedge clk);
         r[i] = spdSdaIn;
         repeat (12) @(posedge clk);
      end
   endtask
   task summarize();
      if (errors == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ===========
   // main sequence
   initial begin
      rst_n = 1'b0;
      moduleRst_n = 1'b1;
      regWr = 1'b0;
      regRd = 1'b0;
      regAddr = 4'h0;
      regWrData = 32'h0;
      spdScl = 1'b1;
      mSda = 1'b1;
      serialAddrSelect = 3'h5;
      coreRdData = 64'h0;
      tempNow = 8'h0;
      errors = 0;
      samples_checked = 0;
      lfsrState = 32'h6CA86A3C;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      regRead(REG_CTRL, d);
      checkVal(d, 32'(CL_RESET) << CTRL_CL_LSB);
      regRead(REG_TEMP, d);
      checkVal(d, {16'h0, CRIT_TH_RESET, EVT_TH_RESET});
      regRead(4'h2, d);
      checkVal(d, 64'h0);
      regWrite(REG_TEMP, 32'h6040);
      for (int i = 0; i < 12; i++) begin
         d = (i < 2) ? 32'h3F + i : rnd();
         @(posedge clk);
         tempNow <= d[7:0];
         repeat (2) @(posedge clk);
         #1;
         checkVal({eventO, eventOe}, expEvent(tempNow, 8'h40, 8'h60));
      end
      for (int i = 0; i < 6; i++) begin
         d = rnd();
         c = mfe_cmd_t'(d[23:0]);
         c.csN = 1'b1;
         host.send(c, i[0]);
         checkVal({errOutO, errOutOe}, i[0]);
         @(posedge hostCk);
         #40;
         checkVal({dramCk, dramCmd}, {1'b1, c});
      end
      regRead(REG_STAT, d);
      checkVal(d[STAT_PERR_BIT], 1'b1);
      regWrite(REG_STAT, 32'h1);
      regRead(REG_STAT, d);
      checkVal(d[STAT_PERR_BIT], 1'b0);
      for (int m = 0; m < 4; m++) begin
         cl = (m == 3) ? 3'h0 : 3'(m + 2);
         clv = (cl == 3'h0) ? 8 : int'(cl);
         regWrite(REG_CTRL, {25'h0, cl, 2'h0, 2'(m)});
         coreRdData <= {rnd(), rnd()};
         host.send(opCmd(1'b0), 1'b0);
         repeat (clv) @(posedge hostCk);
         #40;
         checkVal(dqOe, 1'b0);
         @(posedge hostCk);
         #40;
         for (int b = 0; b < 8; b++) begin
            checkVal(dqO, coreRdData[8*b +: 8]);
            checkVal(lane, expLane(2'(m), b[0]));
            #80;
         end
         checkVal({dqOe, dqsOe, redStrobeOe}, 64'h0);
      end
      for (int m = 0; m < 2; m++) begin
         regWrite(REG_CTRL, {28'h003, 4'(m)});
         wd = {rnd(), rnd()};
         d = rnd();
         mk = d[7:0] | 8'h81;
         host.send(opCmd(1'b1), 1'b0);
         @(posedge hostCk);
         #40;
         fork
            host.wrBurst(wd, mk);
            begin
               k = 0;
               while (coreWrValid !== 1'b1 && k < 400) begin
                  @(posedge clk);
                  #1;
                  k++;
               end
               gotD = coreWrData;
               gotM = coreWrMask;
            end
         join
         if (k >= 400) begin
            errors++;
            summarize();
         end
         checkVal(gotD, wd);
         checkVal(gotM, (m == 0) ? mk : 8'h00);
      end
      // presence store: foreign select refused, upper byte written, read back
      i2cCond(1'b1, 1'b0);
      i2cXfer({SPD_DEV_TYPE, ~serialAddrSelect, 2'h1}, r9);
      checkVal(r9[0], 1'b1);
      i2cCond(1'b1, 1'b0);
      i2cXfer({SPD_DEV_TYPE, serialAddrSelect, 2'h1}, r9);
      checkVal({spdSdaO, r9[0]}, 2'h0);
      d = rnd();
      i2cXfer({1'b1, d[6:0], 1'b1}, r9);
      checkVal(r9[0], 1'b0);
      i2cXfer({d[15:8], 1'b1}, r9);
      checkVal(r9[0], 1'b0);
      i2cCond(1'b1, 1'b0);
      i2cXfer({SPD_DEV_TYPE, serialAddrSelect, 2'h1}, r9);
      i2cXfer({1'b1, d[6:0], 1'b1}, r9);
      i2cCond(1'b1, 1'b0);
      i2cXfer({SPD_DEV_TYPE, serialAddrSelect, 2'h3}, r9);
      checkVal(r9[0], 1'b0);
      i2cXfer(9'h1FF, r9);
      checkVal(r9[8:1], d[15:8]);
      i2cCond(1'b0, 1'b1);
      @(posedge clk);
      moduleRst_n <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      checkVal({dramCmd, errOutOe}, 64'h0);
      @(posedge clk);
      moduleRst_n <= 1'b1;
      summarize();
   end
endmodule
